/* inc/pbr_pkg.sv */
// Constants and state encoding for the push-button reset control block
//
// Functional notes
// - The button input serves both power enable and, when pulled hard to ground, manual reset.
// - An internal timer measures each manual-reset press and its length picks the action.
// - A press under 4 s pulls processor reset low at once until release plus the reset time-out.
// - A soft reset sets the soft-reset flag, which clears to 0 when software reads it.
// - A press over 4 s power-cycles the system, turning every regulator off then on again.
// - A power cycle sets the power-cycle flag, which clears to 0 when software reads it.
// - The button-state output is pulled low while the button is asserted, else left floating.
// - At startup processor reset is held low until the reset time-out expires.
// - The interrupt output is pulled low while any unmasked interrupt condition stands.
// - Interrupt sources are masked after reset and are unmasked one by one by the host.
// - A resistor-coupled button press starts the power-on enable sequence.
// - Power-hold must be high before the button is released or the boot aborts; it keeps power on.
// - With watchdog soft-reset enabled, a 4 s watchdog restarted by each host access soft-resets.
package pbr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint unsigned PBR_CLK_HZ = 64'd125_000_000;
  localparam longint unsigned PBR_LONG_PRESS_S = 64'd4;
  localparam longint unsigned PBR_WATCHDOG_S = 64'd4;
  localparam longint unsigned PBR_DEBOUNCE_MS = 64'd20;
  localparam int unsigned PBR_LONG_PRESS_CYCLES = 32'(PBR_LONG_PRESS_S * PBR_CLK_HZ);
  localparam int unsigned PBR_WATCHDOG_CYCLES = 32'(PBR_WATCHDOG_S * PBR_CLK_HZ);
  localparam int unsigned PBR_DEBOUNCE_CYCLES = 32'((PBR_DEBOUNCE_MS * PBR_CLK_HZ) / 64'd1000);
  localparam int unsigned PBR_RESET_TIMEOUT_CYCLES = 32'd1000;
  localparam int unsigned PBR_CYCLE_OFF_CYCLES = 32'd1000;

  // ----------------------------------------------------------------
  // Interrupt sources and input channels
  // ----------------------------------------------------------------
  localparam int unsigned PBR_IRQ_SOFT_RESET = 0;
  localparam int unsigned PBR_IRQ_POWER_CYCLE = 1;
  localparam int unsigned PBR_IRQ_COUNT = 2;
  localparam logic [1:0] PBR_UNMASK_RESET = 2'h0;
  localparam int unsigned PBR_CH_PRESS = 0;
  localparam int unsigned PBR_CH_HARD = 1;
  localparam int unsigned PBR_CH_COUNT = 2;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    PBR_ST_OFF = 6'h01,
    PBR_ST_BOOT = 6'h02,
    PBR_ST_ON = 6'h04,
    PBR_ST_PRESS = 6'h08,
    PBR_ST_RESET_HOLD = 6'h10,
    PBR_ST_CYCLE_OFF = 6'h20
  } pbr_state_t;

endpackage : pbr_pkg

/* rtl/pbr_debounce.sv */
// Debounce filter for one synchronised active-low level
module pbr_debounce
  import pbr_pkg::*;
#(
  parameter int unsigned CYCLES = PBR_DEBOUNCE_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic level_n_i,
  output logic level_n_o
);

  logic [31:0] count;

  // ----------------------------------------------------------------
  // Accept a new level only after it has stood for CYCLES cycles
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count <= 32'h0;
      level_n_o <= 1'b1;
    end else if (level_n_i == level_n_o) begin
      count <= 32'h0;
    end else if (count >= CYCLES - 32'd1) begin
      count <= 32'h0;
      level_n_o <= level_n_i;
    end else begin
      count <= count + 32'h1;
    end
  end

endmodule : pbr_debounce

/* rtl/pbr_top.sv */
// Push-button power sequencing and manual reset supervisor
module pbr_top
  import pbr_pkg::*;
#(
  parameter int unsigned LONG_PRESS_CYCLES = PBR_LONG_PRESS_CYCLES,
  parameter int unsigned WATCHDOG_CYCLES = PBR_WATCHDOG_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = PBR_DEBOUNCE_CYCLES,
  parameter int unsigned RESET_TIMEOUT_CYCLES = PBR_RESET_TIMEOUT_CYCLES,
  parameter int unsigned CYCLE_OFF_CYCLES = PBR_CYCLE_OFF_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic push_button_in_n_i,
  input wire logic hard_press_in_n_i,
  input wire logic power_hold_in_i,
  input wire logic power_enable_in_i,
  input wire logic watchdog_soft_reset_enable_i,
  input wire logic host_access_i,
  input wire logic soft_reset_flag_read_i,
  input wire logic power_cycle_flag_read_i,
  input wire logic unmask_write_i,
  input wire logic [1:0] unmask_data_i,
  output logic button_state_out_n_o,
  output logic button_state_out_n_oe_o,
  output logic processor_reset_out_n_o,
  output logic processor_reset_out_n_oe_o,
  output logic interrupt_request_out_n_o,
  output logic interrupt_request_out_n_oe_o,
  output logic soft_reset_flag_o,
  output logic power_cycle_flag_o,
  output logic [1:0] unmask_o,
  output logic regulators_enable_o,
  output logic sleep_rails_enable_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [PBR_CH_COUNT-1:0] raw_n;
  logic [PBR_CH_COUNT-1:0] sync1_n;
  logic [PBR_CH_COUNT-1:0] sync2_n;
  logic [PBR_CH_COUNT-1:0] clean_n;
  logic pressed;
  logic hard;
  pbr_state_t state;
  pbr_state_t next_state;
  logic [31:0] count;
  logic [31:0] wdog_count;
  logic wdog_expire;
  logic timeout_done;
  logic long_done;
  logic off_done;
  logic set_soft;
  logic set_cycle;
  logic [1:0] level_sync1;
  logic [1:0] level_sync2;
  logic hold_synced;
  logic enable_synced;

  assign raw_n = {hard_press_in_n_i, push_button_in_n_i};

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sync1_n <= '1;
      sync2_n <= '1;
    end else begin
      sync1_n <= raw_n;
      sync2_n <= sync1_n;
    end
  end

  // ----------------------------------------------------------------
  // Level input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      level_sync1 <= 2'h0;
      level_sync2 <= 2'h0;
    end else begin
      level_sync1 <= {power_enable_in_i, power_hold_in_i};
      level_sync2 <= level_sync1;
    end
  end

  assign hold_synced = level_sync2[0];
  assign enable_synced = level_sync2[1];

  // ----------------------------------------------------------------
  // Debounce each channel
  // ----------------------------------------------------------------
  generate
    for (genvar ch = 0; ch < PBR_CH_COUNT; ch++) begin : g_deb
      pbr_debounce #(
        .CYCLES(DEBOUNCE_CYCLES)
      ) u_deb (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .level_n_i(sync2_n[ch]),
        .level_n_o(clean_n[ch])
      );
    end
  endgenerate

  // A hard press is also a press; the resistor path alone is a plain press
  assign pressed = ~clean_n[PBR_CH_PRESS] | ~clean_n[PBR_CH_HARD];
  assign hard = ~clean_n[PBR_CH_HARD];

  // ----------------------------------------------------------------
  // Timer end conditions
  // ----------------------------------------------------------------
  assign timeout_done = count >= RESET_TIMEOUT_CYCLES - 32'd1;
  assign long_done = count >= LONG_PRESS_CYCLES - 32'd1;
  assign off_done = count >= CYCLE_OFF_CYCLES - 32'd1;
  assign wdog_expire = watchdog_soft_reset_enable_i && !host_access_i
    && wdog_count >= WATCHDOG_CYCLES - 32'd1;

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    set_soft = 1'b0;
    set_cycle = 1'b0;
    unique case (state)
      PBR_ST_OFF: begin
        if (pressed && !hard) begin
          next_state = PBR_ST_BOOT;
        end
      end
      PBR_ST_BOOT: begin
        if (!pressed) begin
          if (hold_synced) begin
            next_state = PBR_ST_RESET_HOLD;
          end else begin
            next_state = PBR_ST_OFF;
          end
        end
      end
      PBR_ST_ON: begin
        if (!hold_synced) begin
          next_state = PBR_ST_OFF;
        end else if (hard) begin
          next_state = PBR_ST_PRESS;
        end else if (wdog_expire) begin
          next_state = PBR_ST_RESET_HOLD;
          set_soft = 1'b1;
        end
      end
      PBR_ST_PRESS: begin
        if (long_done) begin
          next_state = PBR_ST_CYCLE_OFF;
        end else if (!pressed) begin
          next_state = PBR_ST_RESET_HOLD;
          set_soft = 1'b1;
        end
      end
      PBR_ST_RESET_HOLD: begin
        if (!pressed && timeout_done) begin
          next_state = PBR_ST_ON;
        end
      end
      PBR_ST_CYCLE_OFF: begin
        if (off_done) begin
          next_state = PBR_ST_RESET_HOLD;
          set_cycle = 1'b1;
        end
      end
      default: begin
        next_state = PBR_ST_OFF;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= PBR_ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Shared duration timer
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      count <= 32'h0;
    end else if (next_state != state) begin
      count <= 32'h0;
    end else if (state == PBR_ST_RESET_HOLD && pressed) begin
      count <= 32'h0;
    end else if (count != 32'hffffffff) begin
      count <= count + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wdog_count <= 32'h0;
    end else if (!watchdog_soft_reset_enable_i || host_access_i || state != PBR_ST_ON) begin
      wdog_count <= 32'h0;
    end else if (wdog_expire) begin
      wdog_count <= 32'h0;
    end else begin
      wdog_count <= wdog_count + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Status flags, set wins over read clear
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      soft_reset_flag_o <= 1'b0;
    end else if (set_soft) begin
      soft_reset_flag_o <= 1'b1;
    end else if (soft_reset_flag_read_i) begin
      soft_reset_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      power_cycle_flag_o <= 1'b0;
    end else if (set_cycle) begin
      power_cycle_flag_o <= 1'b1;
    end else if (power_cycle_flag_read_i) begin
      power_cycle_flag_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt unmask bits
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      unmask_o <= PBR_UNMASK_RESET;
    end else if (unmask_write_i) begin
      unmask_o <= unmask_data_i;
    end
  end

  // ----------------------------------------------------------------
  // Open-drain pins, driven value always low
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      button_state_out_n_o <= 1'b0;
      processor_reset_out_n_o <= 1'b0;
      interrupt_request_out_n_o <= 1'b0;
    end else begin
      button_state_out_n_o <= 1'b0;
      processor_reset_out_n_o <= 1'b0;
      interrupt_request_out_n_o <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      button_state_out_n_oe_o <= 1'b0;
    end else begin
      button_state_out_n_oe_o <= pressed;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      processor_reset_out_n_oe_o <= 1'b1;
    end else begin
      processor_reset_out_n_oe_o <= next_state != PBR_ST_ON;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      interrupt_request_out_n_oe_o <= 1'b0;
    end else begin
      interrupt_request_out_n_oe_o <=
        (soft_reset_flag_o & unmask_o[PBR_IRQ_SOFT_RESET])
        | (power_cycle_flag_o & unmask_o[PBR_IRQ_POWER_CYCLE]);
    end
  end

  // ----------------------------------------------------------------
  // Regulator enables
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      regulators_enable_o <= 1'b0;
      sleep_rails_enable_o <= 1'b0;
    end else begin
      regulators_enable_o <= next_state != PBR_ST_OFF && next_state != PBR_ST_CYCLE_OFF;
      sleep_rails_enable_o <= enable_synced && next_state != PBR_ST_OFF
        && next_state != PBR_ST_CYCLE_OFF;
    end
  end

endmodule : pbr_top

/* testbench/pbr_host_model.sv */
// Host processor model: power hold, periodic accesses and flag reads
module pbr_host_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic regs_on_i,
  input wire logic irq_n_i,
  input wire logic soft_flag_i,
  input wire logic pc_flag_i,
  input wire logic boot_ok_i,
  input wire logic talk_i,
  output logic power_hold_o,
  output logic access_o,
  output logic soft_read_o,
  output logic pc_read_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up;
  logic [3:0] gap;
  logic [1:0] idle;
  always_ff @(posedge clock_i) begin
    if (rst_i || !boot_ok_i) begin
      up <= 3'h0;
      power_hold_o <= 1'b0;
    end else if (regs_on_i && up != 3'h7) begin
      up <= up + 3'h1;
    end else if (up == 3'h7) begin
      power_hold_o <= 1'b1;
    end
  end
  always_ff @(posedge clock_i) begin
    gap <= rst_i ? 4'h0 : gap + 4'h1;
    access_o <= !rst_i && talk_i && gap == 4'hf;
  end
  always_ff @(posedge clock_i) begin
    soft_read_o <= 1'b0;
    pc_read_o <= 1'b0;
    if (rst_i) begin
      idle <= 2'h0;
    end else if (idle != 2'h0) begin
      idle <= idle - 2'h1;
    end else if (!irq_n_i) begin
      soft_read_o <= soft_flag_i;
      pc_read_o <= pc_flag_i;
      idle <= 2'h3;
    end
  end
endmodule : pbr_host_model

/* testbench/pbr_properties.sv */
// Concurrent checks on the push-button reset control ports
module pbr_checker #(
  parameter int unsigned RESET_TIMEOUT_CYCLES = 32'd20,
  parameter int unsigned CYCLE_OFF_CYCLES = 32'd20
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic power_hold_in_i,
  input wire logic soft_reset_flag_read_i,
  input wire logic power_cycle_flag_read_i,
  input wire logic unmask_write_i,
  input wire logic [1:0] unmask_data_i,
  input wire logic button_state_out_n_oe_o,
  input wire logic processor_reset_out_n_oe_o,
  input wire logic interrupt_request_out_n_oe_o,
  input wire logic soft_reset_flag_o,
  input wire logic power_cycle_flag_o,
  input wire logic [1:0] unmask_o,
  input wire logic regulators_enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] relcnt;
  logic [31:0] offcnt;
  logic live;
  assign live = |({power_cycle_flag_o, soft_reset_flag_o} & unmask_o);
  always_ff @(posedge clock_i) begin
    if (rst_i || button_state_out_n_oe_o || !processor_reset_out_n_oe_o) relcnt <= '0;
    else relcnt <= relcnt + 32'd1;
  end
  always_ff @(posedge clock_i) begin
    if (rst_i || regulators_enable_o) offcnt <= '0;
    else offcnt <= offcnt + 32'd1;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_start_reset;
    $fell(rst_i) |-> processor_reset_out_n_oe_o && !regulators_enable_o;
  endproperty
  a_start_reset: assert property (p_start_reset) else $error("reset not held");
  property p_mask_reset;
    $fell(rst_i) |-> unmask_o == 2'h0 && !interrupt_request_out_n_oe_o;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("irq not masked");
  property p_release;
    $fell(processor_reset_out_n_oe_o) |-> relcnt >= RESET_TIMEOUT_CYCLES - 2;
  endproperty
  a_release: assert property (p_release) else $error("reset released early");
  property p_release_due;
    relcnt == RESET_TIMEOUT_CYCLES + 4 && regulators_enable_o |-> !processor_reset_out_n_oe_o;
  endproperty
  a_release_due: assert property (p_release_due) else $error("reset held too long");
  property p_irq;
    1'b1 |=> interrupt_request_out_n_oe_o == $past(live);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
  property p_unmask_wr;
    unmask_write_i |=> unmask_o == $past(unmask_data_i);
  endproperty
  a_unmask_wr: assert property (p_unmask_wr) else $error("unmask not written");
  property p_soft_clear;
    soft_reset_flag_read_i && soft_reset_flag_o |=> !soft_reset_flag_o;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft flag kept");
  property p_pc_clear;
    power_cycle_flag_read_i && power_cycle_flag_o |=> !power_cycle_flag_o;
  endproperty
  a_pc_clear: assert property (p_pc_clear) else $error("cycle flag kept");
  property p_cycle_off;
    $rose(regulators_enable_o) && power_hold_in_i |->
      offcnt >= CYCLE_OFF_CYCLES - 1 && offcnt <= CYCLE_OFF_CYCLES + 2;
  endproperty
  a_cycle_off: assert property (p_cycle_off) else $error("off interval wrong");
  c_soft: cover property ($rose(soft_reset_flag_o));
  c_pc: cover property ($rose(power_cycle_flag_o));
  c_irq: cover property ($rose(interrupt_request_out_n_oe_o));
endmodule : pbr_checker

bind pbr_top pbr_checker #(.RESET_TIMEOUT_CYCLES(RESET_TIMEOUT_CYCLES),
  .CYCLE_OFF_CYCLES(CYCLE_OFF_CYCLES)) u_chk (.clock_i(clock_i), .rst_i(rst_i),
  .power_hold_in_i(power_hold_in_i), .soft_reset_flag_read_i(soft_reset_flag_read_i),
  .power_cycle_flag_read_i(power_cycle_flag_read_i), .unmask_write_i(unmask_write_i),
  .unmask_data_i(unmask_data_i), .button_state_out_n_oe_o(button_state_out_n_oe_o),
  .processor_reset_out_n_oe_o(processor_reset_out_n_oe_o),
  .interrupt_request_out_n_oe_o(interrupt_request_out_n_oe_o),
  .soft_reset_flag_o(soft_reset_flag_o), .power_cycle_flag_o(power_cycle_flag_o),
  .unmask_o(unmask_o), .regulators_enable_o(regulators_enable_o));

/* testbench/tb_top.sv */
// Self-checking bench for the push-button reset control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LP = 200;
  localparam int WD = 300;
  localparam int RT = 20;
  localparam int CO = 20;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic pb_n = 1'b1;
  logic hard_n = 1'b1;
  logic pe, wde, umw, boot_ok, talk, irq_w, hold, acc, srd, prd;
  logic bs_n, bs_oe, rs_n, rs_oe, irq_n, irq_oe, sf, pf, regs, sleep;
  logic [1:0] umd;
  logic [1:0] um;
  logic [5:0] obs;
  int failures = 0;
  int num_checks = 0;
  assign irq_w = irq_oe ? irq_n : 1'b1;
  assign obs = {pf, sf, regs, irq_oe, rs_oe, bs_oe};
  always #4 clock_i = ~clock_i;
  pbr_top #(.LONG_PRESS_CYCLES(LP), .WATCHDOG_CYCLES(WD), .DEBOUNCE_CYCLES(4),
    .RESET_TIMEOUT_CYCLES(RT), .CYCLE_OFF_CYCLES(CO)) dut (.clock_i(clock_i),
    .rst_i(rst_i), .push_button_in_n_i(pb_n), .hard_press_in_n_i(hard_n),
    .power_hold_in_i(hold), .power_enable_in_i(pe), .watchdog_soft_reset_enable_i(wde),
    .host_access_i(acc), .soft_reset_flag_read_i(srd), .power_cycle_flag_read_i(prd),
    .unmask_write_i(umw), .unmask_data_i(umd), .button_state_out_n_o(bs_n),
    .button_state_out_n_oe_o(bs_oe), .processor_reset_out_n_o(rs_n),
    .processor_reset_out_n_oe_o(rs_oe), .interrupt_request_out_n_o(irq_n),
    .interrupt_request_out_n_oe_o(irq_oe), .soft_reset_flag_o(sf),
    .power_cycle_flag_o(pf), .unmask_o(um), .regulators_enable_o(regs),
    .sleep_rails_enable_o(sleep));
  pbr_host_model u_host (.clock_i(clock_i), .rst_i(rst_i), .regs_on_i(regs),
    .irq_n_i(irq_w), .soft_flag_i(sf), .pc_flag_i(pf), .boot_ok_i(boot_ok),
    .talk_i(talk), .power_hold_o(hold), .access_o(acc), .soft_read_o(srd),
    .pc_read_o(prd));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [1:0] exp_flags(input int len);
    return (len > LP) ? 2'b10 : 2'b01;
  endfunction : exp_flags
  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int s, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (obs[s] !== v && n < lim);
    chk({1'b0, obs[s]}, {1'b0, v});
    if (obs[s] !== v) stop_test();
  endtask : wt
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc
  task automatic push(input logic hard);
    @(posedge clock_i);
    pb_n <= 1'b0;
    hard_n <= ~hard;
  endtask : push
  task automatic rel();
    @(posedge clock_i);
    pb_n <= 1'b1;
    hard_n <= 1'b1;
  endtask : rel
  task automatic wr_mask(input logic [1:0] v);
    @(posedge clock_i);
    umw <= 1'b1;
    umd <= v;
    @(posedge clock_i);
    umw <= 1'b0;
  endtask : wr_mask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int len;
    int lens [4];
    logic [1:0] d;
    logic [1:0] e;
    void'($urandom(76921));
    pe = 1'b0;
    wde = 1'b0;
    umw = 1'b0;
    umd = 2'h0;
    boot_ok = 1'b0;
    talk = 1'b1;
    lens = '{30, LP - 40, LP + 40, 20 + int'($urandom % 120)};
    cyc(10);
    rst_i <= 1'b0;
    pe <= 1'($urandom % 2);
    @(negedge clock_i);
    chk({rs_oe, regs}, 2'b10);
    chk(um, 2'h0);
    @(posedge clock_i);
    pb_n <= 1'b0;
    @(posedge clock_i);
    pb_n <= 1'b1;
    cyc(20);
    @(negedge clock_i);
    chk({bs_oe, regs}, 2'b00);
    $display("test glitch done");
    push(1'b0);
    wt(0, 1'b1, 20);
    wt(3, 1'b1, 20);
    rel();
    wt(0, 1'b0, 20);
    wt(3, 1'b0, 20);
    $display("test boot abort done");
    boot_ok <= 1'b1;
    push(1'b0);
    wt(3, 1'b1, 20);
    cyc(20);
    rel();
    cyc(RT);
    @(negedge clock_i);
    chk({1'b0, rs_oe}, 2'h1);
    wt(1, 1'b0, 30);
    chk({1'b0, regs}, 2'h1);
    chk({sleep, regs}, {pe, 1'b1});
    chk({bs_n, rs_n}, 2'b00);
    chk({1'b0, irq_n}, 2'h0);
    $display("test boot done");
    for (int i = 0; i < 4; i++) begin
      len = lens[i];
      push(1'b1);
      wt(1, 1'b1, 12);
      if (len > LP) begin
        wt(3, 1'b0, LP + 20);
        wt(3, 1'b1, CO + 10);
      end
      cyc(len > LP ? 20 : len);
      rel();
      wt(1, 1'b0, RT + 30);
      chk({pf, sf}, exp_flags(len));
      d = 2'($urandom % 4);
      e = exp_flags(len) & d;
      wr_mask(d);
      cyc(1);
      @(negedge clock_i);
      chk({1'b0, irq_oe}, {1'b0, |e});
      wr_mask(2'h3);
      wt(4, 1'b0, 12);
      wt(5, 1'b0, 12);
      wt(2, 1'b0, 6);
      wr_mask(2'h0);
      $display("test manual reset %0d done", len);
    end
    @(posedge clock_i);
    wde <= 1'b1;
    cyc(WD + 100);
    @(negedge clock_i);
    chk({1'b0, rs_oe}, 2'h0);
    talk <= 1'b0;
    wt(1, 1'b1, WD + 20);
    chk({1'b0, sf}, 2'h1);
    @(posedge clock_i);
    wde <= 1'b0;
    talk <= 1'b1;
    wt(1, 1'b0, RT + 10);
    $display("test watchdog done");
    boot_ok <= 1'b0;
    wt(3, 1'b0, 20);
    chk({1'b0, sleep}, 2'h0);
    $display("test power off done");
    stop_test();
  end
endmodule : tb_top
